// ===== sac_pkg.sv
// Constants, state codes and timing counts shared by the conversion control.
// Assumes a single system clock at the rate held in SYS_CLK_MHZ.

`default_nettype none

package sac_pkg;

   // ------------------------------------------------------------------
   // Result format
   // ------------------------------------------------------------------
   localparam int RESULT_BITS = 12;
   localparam logic [3:0] MSB_INDEX = 4'hb;
   localparam logic [11:0] TWOS_FLIP = 12'h800;
   localparam logic [11:0] TRIAL_START = 12'h800;
   localparam logic [11:0] TRIAL_RST = 12'h000;
   localparam logic [11:0] RESULT_RST = 12'h000;

   // ------------------------------------------------------------------
   // Conversion clock positions, counted in falling edges from the trigger
   // ------------------------------------------------------------------
   localparam logic [4:0] CNT_RST = 5'h00;
   localparam logic [4:0] CLK_START = 5'h01;
   localparam logic [4:0] CLK_MSB = 5'h02;
   localparam logic [4:0] CLK_LSB = 5'h0d;
   localparam logic [4:0] CLK_RESULT_END = 5'h0e;
   localparam logic [4:0] CLK_PER_SAMPLE_HOLD_TRIGGER = 5'h10;
   localparam logic [4:0] LSBF_RESEND = 5'h0b;
   localparam logic [4:0] CLK_LSBF_END = CLK_LSB + LSBF_RESEND + 5'h01;

   // ------------------------------------------------------------------
   // Host timing figures and their cycle counts
   // ------------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 125;
   localparam int ACQUIRE_MIN_TIME_NS = 350;
   localparam int HOLD_TO_CLOCK_LIMIT_NS = 5000;
   localparam int ACQ_CYC = (ACQUIRE_MIN_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int DRP_CYC = (HOLD_TO_CLOCK_LIMIT_NS * SYS_CLK_MHZ) / 1000;
   localparam int TIMER_W = 10;
   localparam logic [9:0] ACQ_LIMIT = 10'(ACQ_CYC);
   localparam logic [9:0] DRP_LIMIT = 10'(DRP_CYC);
   localparam logic [9:0] TIMER_RST = 10'h000;

   // ------------------------------------------------------------------
   // Control states
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_SAMPLE = 4'h1,
      ST_CONVERT = 4'h2,
      ST_LSB_FIRST = 4'h4,
      ST_POWER_DOWN = 4'h8
   } sac_state_t;

endpackage

`default_nettype wire

// ===== sac_pin_sync.sv
// Two-stage synchroniser for one pin, with rise and fall pulses.
// Assumes the pin is asynchronous to sys_clk and changes slower than it.

`timescale 1ns/1ps
`default_nettype none

module sac_pin_sync (
   input wire logic sys_clk, // System clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic pinIn, // Raw pin level.
   output logic level, // Synchronised level.
   output logic rise, // One-cycle pulse on a rising level.
   output logic fall // One-cycle pulse on a falling level.
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // The first stage is read only by the second stage.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pinIn;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Edges compare the settled stage against its own delayed copy.
   assign level = sync_q;
   assign rise = sync_q & ~last_q;
   assign fall = ~sync_q & last_q;

endmodule

`default_nettype wire

// ===== sac_sample_hold_trigger_ctrl.sv
// Conversion sequencing and serial result output of a sampling converter.
// Assumes the trigger, conversion clock and comparator arrive asynchronously
// and that the board resolves the three-state data pin from its enable.

`timescale 1ns/1ps
`default_nettype none

// Operation
// - Trigger falling edge switches sample to hold, whatever the clock does.
// - Trigger timing slips still convert correctly, start may move one clock.
// - Data is high impedance before conversion, drives low in first clock.
// - Trigger low throughout and at clock thirteen enters power-down.
// - Power-down lasts until the next trigger rising edge.
// - First conversion after power-down is valid, with no extra latency.
// - LSB-first resends the remaining eleven bits, least significant first.
// - LSB-first enters power-down in clock thirteen until trigger changes.
// - Each falling clock edge moves the output to the next bit.
// - Data goes high impedance on trigger change and after the result.
// - Without power-down, sampling resumes at the cycle's final falling edge.
// - Trigger rising edge restores sampling and full power; a rise before clock thirteen leaves the code converting, not sampling.
// - Result goes out MSB first, from the conversion in progress.
// - Result is two's complement: 7ff top, 000 zero, 800 bottom.
module sac_sample_hold_trigger_ctrl #(
   parameter int RESULT_BITS = sac_pkg::RESULT_BITS
) (
   input wire logic sys_clk, // System clock, 125 MHz.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic sampleHoldTrigger, // Conversion trigger pin.
   input wire logic convClk, // Conversion clock pin.
   input wire logic compHigh, // Comparator: input above trial level.
   output logic serialData, // Serial result bit.
   output logic serialDataOe, // High while serialData drives the pin.
   output logic sampleMode, // High while sampling, low while holding.
   output logic powerDown, // High while powered down.
   output logic [11:0] dacTrial, // Trial code to the capacitor DAC.
   output logic [11:0] resultWord, // Last result, two's complement.
   output logic resultValid, // One-cycle pulse when resultWord updates.
   output logic acquireShort, // Last hold began before acquisition time.
   output logic holdDroopLate // Clock started too late after hold.
);

   // ------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------
   if (RESULT_BITS != sac_pkg::RESULT_BITS) begin : g_bad_width
      $error("sac_sample_hold_trigger_ctrl supports a twelve bit result only.");
   end

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic trigLevel;
   logic trigRise;
   logic trigFall;
   logic clkFall;
   logic compLevel;

   // Trigger edges are seen two cycles late at most; no clock is needed.
   sac_pin_sync u_trig_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pinIn(sampleHoldTrigger),
      .level(trigLevel),
      .rise(trigRise),
      .fall(trigFall)
   );

   // Only the falling edges of the conversion clock move the sequence.
   sac_pin_sync u_clk_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pinIn(convClk),
      .level(),
      .rise(),
      .fall(clkFall)
   );

   // The comparator decision is sampled as a level.
   sac_pin_sync u_comp_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pinIn(compHigh),
      .level(compLevel),
      .rise(),
      .fall()
   );

   // ------------------------------------------------------------------
   // Sequence state
   // ------------------------------------------------------------------
   sac_pkg::sac_state_t state_q;
   sac_pkg::sac_state_t state_d;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic [4:0] cntNext;
   logic armLsb_q;
   logic [3:0] bitIdx;
   logic inBits;
   logic bitTwos;
   logic [11:0] resultNow;

   // Falling clock edge count as it stands after the current edge.
   assign cntNext = cnt_q + 5'h01;

   // Bit index presented at this edge, MSB at the second clock.
   assign bitIdx = 4'(sac_pkg::CLK_LSB - cntNext);
   assign inBits = (cntNext >= sac_pkg::CLK_MSB) && (cntNext <= sac_pkg::CLK_LSB);

   // The MSB is inverted so offset binary becomes two's complement.
   assign bitTwos = compLevel ^ (bitIdx == sac_pkg::MSB_INDEX);

   // Full word once the last bit is decided at the thirteenth edge.
   assign resultNow = {dacTrial[11:1], compLevel} ^ sac_pkg::TWOS_FLIP;

   // Next state and count; trigger edges win over clock edges.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         sac_pkg::ST_SAMPLE: begin
            if (trigFall) begin
               state_d = sac_pkg::ST_CONVERT;
               cnt_d = sac_pkg::CNT_RST;
            end
         end
         sac_pkg::ST_CONVERT: begin
            if (trigFall && armLsb_q && (cnt_q == sac_pkg::CLK_LSB)) begin
               state_d = sac_pkg::ST_LSB_FIRST;
            end else if (trigFall) begin
               cnt_d = sac_pkg::CNT_RST;
            end else if (trigRise && (cnt_q >= sac_pkg::CLK_LSB)) begin
               state_d = sac_pkg::ST_SAMPLE;
            end else if (clkFall) begin
               cnt_d = cntNext;
               if (cntNext == sac_pkg::CLK_PER_SAMPLE_HOLD_TRIGGER) begin
                  // Cycle end: sample again unless powered down.
                  if (powerDown) begin
                     state_d = sac_pkg::ST_POWER_DOWN;
                  end else begin
                     state_d = sac_pkg::ST_SAMPLE;
                  end
               end
            end
         end
         sac_pkg::ST_LSB_FIRST: begin
            if (trigRise) begin
               state_d = sac_pkg::ST_SAMPLE;
            end else if (clkFall) begin
               cnt_d = cntNext;
               if (cntNext == sac_pkg::CLK_LSBF_END) begin
                  state_d = sac_pkg::ST_POWER_DOWN;
               end
            end
         end
         sac_pkg::ST_POWER_DOWN: begin
            if (trigRise) begin
               state_d = sac_pkg::ST_SAMPLE;
            end else if (trigFall) begin
               state_d = sac_pkg::ST_CONVERT;
               cnt_d = sac_pkg::CNT_RST;
            end
         end
         default: begin
            state_d = sac_pkg::ST_SAMPLE;
            cnt_d = sac_pkg::CNT_RST;
         end
      endcase
   end

   // State and clock count registers.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= sac_pkg::ST_SAMPLE;
         cnt_q <= sac_pkg::CNT_RST;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // A trigger rise mid-conversion arms the LSB-first request.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         armLsb_q <= 1'b0;
      end else if (state_d != sac_pkg::ST_CONVERT || cnt_d == sac_pkg::CNT_RST) begin
         armLsb_q <= 1'b0;
      end else if (trigRise && cnt_q < sac_pkg::CLK_LSB) begin
         armLsb_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Sample switch and power
   // ------------------------------------------------------------------

   // Sampling follows the next state, so hold starts on the trigger fall.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sampleMode <= 1'b1;
      end else begin
         sampleMode <= (state_d == sac_pkg::ST_SAMPLE);
      end
   end

   // Power-down is entered at clock thirteen and left on a trigger rise.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         powerDown <= 1'b0;
      end else if (trigRise || state_d == sac_pkg::ST_SAMPLE) begin
         powerDown <= 1'b0;
      end else if (state_d == sac_pkg::ST_LSB_FIRST) begin
         powerDown <= 1'b1;
      end else if (state_q == sac_pkg::ST_CONVERT && clkFall && !trigFall &&
                   cntNext == sac_pkg::CLK_LSB && !trigLevel && !armLsb_q) begin
         powerDown <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Successive approximation
   // ------------------------------------------------------------------

   // Edge one tries the MSB; each later edge to thirteen fixes one bit and tries the next, if any.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dacTrial <= sac_pkg::TRIAL_RST;
      end else if (state_q == sac_pkg::ST_CONVERT && clkFall && !trigFall) begin
         if (cntNext == sac_pkg::CLK_START) begin
            dacTrial <= sac_pkg::TRIAL_START;
         end else if (inBits) begin
            dacTrial[bitIdx] <= compLevel;
            if (bitIdx != 4'h0) begin
               dacTrial[bitIdx - 4'h1] <= 1'b1;
            end
         end
      end
   end

   // The finished word is kept for the LSB-first resend.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         resultWord <= sac_pkg::RESULT_RST;
         resultValid <= 1'b0;
      end else if (state_q == sac_pkg::ST_CONVERT && clkFall && !trigFall &&
                   cntNext == sac_pkg::CLK_LSB) begin
         resultWord <= resultNow;
         resultValid <= 1'b1;
      end else begin
         resultValid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Serial data pin
   // ------------------------------------------------------------------

   // Bits change only after a falling clock edge and release on trigger edges.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         serialData <= 1'b0;
         serialDataOe <= 1'b0;
      end else if (trigRise || trigFall) begin
         serialDataOe <= 1'b0;
      end else if (clkFall) begin
         case (state_q)
            sac_pkg::ST_CONVERT: begin
               if (cntNext == sac_pkg::CLK_START) begin
                  serialData <= 1'b0;
                  serialDataOe <= 1'b1;
               end else if (inBits && !armLsb_q) begin
                  serialData <= bitTwos;
               end else if (cntNext == sac_pkg::CLK_RESULT_END) begin
                  serialDataOe <= 1'b0;
               end
            end
            sac_pkg::ST_LSB_FIRST: begin
               if (cntNext < sac_pkg::CLK_LSBF_END) begin
                  serialData <= resultWord[4'(cntNext - sac_pkg::CLK_LSB)];
                  serialDataOe <= 1'b1;
               end else begin
                  serialDataOe <= 1'b0;
               end
            end
            default: begin
               serialDataOe <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Host timing monitors
   // ------------------------------------------------------------------
   logic [9:0] acqCnt_q;
   logic [9:0] holdCnt_q;
   logic holdWait_q;

   // Counts sampling time since the trigger rose, saturating at the limit.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         acqCnt_q <= sac_pkg::ACQ_LIMIT;
      end else if (trigRise) begin
         acqCnt_q <= sac_pkg::TIMER_RST;
      end else if (trigLevel && acqCnt_q < sac_pkg::ACQ_LIMIT) begin
         acqCnt_q <= acqCnt_q + 10'h001;
      end
   end

   // A hold that begins before the acquisition time is flagged.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         acquireShort <= 1'b0;
      end else if (trigFall) begin
         acquireShort <= (acqCnt_q < sac_pkg::ACQ_LIMIT);
      end
   end

   // Measures the wait from hold to the first falling clock edge.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         holdCnt_q <= sac_pkg::TIMER_RST;
         holdWait_q <= 1'b0;
      end else if (trigFall) begin
         holdCnt_q <= sac_pkg::TIMER_RST;
         holdWait_q <= 1'b1;
      end else if (clkFall || trigRise) begin
         holdWait_q <= 1'b0;
      end else if (holdWait_q && holdCnt_q < sac_pkg::DRP_LIMIT) begin
         holdCnt_q <= holdCnt_q + 10'h001;
      end
   end

   // The droop flag marks a conversion whose clock came too late.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         holdDroopLate <= 1'b0;
      end else if (trigFall) begin
         holdDroopLate <= 1'b0;
      end else if (holdWait_q && holdCnt_q >= sac_pkg::DRP_LIMIT) begin
         holdDroopLate <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// ===== sac_sample_hold_trigger_ctrl_assertions.sv
// Concurrent checks on the ports of the conversion control.
// Assumes it is bound to sac_sample_hold_trigger_ctrl and sees only its ports.

`timescale 1ns/1ps
`default_nettype none

module sac_sample_hold_trigger_ctrl_assertions #(
   parameter int RESULT_BITS = 12
) (
   input wire logic sys_clk, // System clock.
   input wire logic rst_b, // Reset, active low.
   input wire logic sampleHoldTrigger, // Trigger pin.
   input wire logic convClk, // Conversion clock pin.
   input wire logic compHigh, // Comparator decision.
   input wire logic serialData, // Serial result bit.
   input wire logic serialDataOe, // Data pin enable.
   input wire logic sampleMode, // Sampling flag.
   input wire logic powerDown, // Power-down flag.
   input wire logic [11:0] dacTrial, // Trial code.
   input wire logic [11:0] resultWord, // Last result.
   input wire logic resultValid, // Result update pulse.
   input wire logic acquireShort, // Short acquisition flag.
   input wire logic holdDroopLate // Late clock flag.
);
   // All checks share the system clock and its reset.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   AST_HOLD_ON_FALL:
   assert property ($fell(sampleHoldTrigger) && sampleMode |-> ##[2:5] !sampleMode)
      else $error("sampling did not stop after trigger fall");
   AST_WAKE_ON_RISE:
   assert property ($rose(sampleHoldTrigger) && powerDown |-> ##[2:5] (sampleMode && !powerDown))
      else $error("no wake after trigger rise");
   AST_RELEASE_ON_TRIGGER:
   assert property ($changed(sampleHoldTrigger) |-> ##[2:5] !serialDataOe)
      else $error("data pin not released after trigger change");
   AST_START_LOW:
   assert property ($rose(serialDataOe) && !powerDown |-> !serialData)
      else $error("first driven bit is not low");
   AST_QUIET_WHILE_SAMPLING:
   assert property (sampleMode && $past(sampleMode) |-> !serialDataOe)
      else $error("data pin driven while sampling");
   AST_DATA_ON_CLK_LOW:
   assert property (serialDataOe && $changed(serialData) |-> !convClk)
      else $error("data changed while clock high");
   AST_SLEEP_ONLY_LOW:
   assert property ($rose(powerDown) |-> !sampleHoldTrigger && !sampleMode)
      else $error("power-down entered with trigger high");
   AST_WAKE_NEEDS_TRIGGER:
   assert property ($fell(powerDown) |-> sampleMode && sampleHoldTrigger)
      else $error("power-down left without trigger high");
   AST_LAST_BIT_MATCHES:
   assert property (resultValid && serialDataOe |-> serialData == resultWord[0])
      else $error("last bit differs from result");
   AST_SAMPLE_AFTER_END:
   assert property ($rose(sampleMode) |-> !serialDataOe && !powerDown)
      else $error("sampling resumed with pin driven or asleep");
   AST_VALID_PULSE:
   assert property (resultValid |=> !resultValid)
      else $error("result pulse longer than one cycle");
endmodule

bind sac_sample_hold_trigger_ctrl sac_sample_hold_trigger_ctrl_assertions #(.RESULT_BITS(RESULT_BITS)) u_chk (
   .sys_clk(sys_clk), .rst_b(rst_b), .sampleHoldTrigger(sampleHoldTrigger),
   .convClk(convClk), .compHigh(compHigh), .serialData(serialData),
   .serialDataOe(serialDataOe), .sampleMode(sampleMode), .powerDown(powerDown),
   .dacTrial(dacTrial), .resultWord(resultWord), .resultValid(resultValid),
   .acquireShort(acquireShort), .holdDroopLate(holdDroopLate));

`default_nettype wire

// ===== sac_host_model.sv
// Host serial port that triggers conversions and clocks out the result.
// Assumes a pulled-up data pin; the enable is a probe to tell release apart.

`timescale 1ns/1ps
`default_nettype none

module sac_host_model (
   input wire logic sys_clk, // System clock.
   input wire logic dataPin, // Resolved data pin level.
   input wire logic dataOe, // Device enable on the data pin.
   output logic sampleHoldTrigger, // Trigger pin.
   output logic convClk // Conversion clock pin.
);
   logic capBit [0:31];
   logic capOe [0:31];

   // Trigger idles high, clock parks low between frames.
   initial begin
      sampleHoldTrigger = 1'b1;
      convClk = 1'b0;
   end

   // One frame: nClk clocks, trigger raised or lowered after given clocks.
   // A frame that breaks host timing on purpose uses a short acqWait or a long clkDelay.
   task automatic frame(input int nClk, input int riseAt, input int fallAt, input int phase,
                        input int acqWait, input int clkDelay);
      repeat (acqWait) @(posedge sys_clk); // Trigger high first, 50 cycles is 400 ns.
      sampleHoldTrigger <= 1'b0;
      repeat (clkDelay) @(posedge sys_clk); // Clock gated on after the fall.
      for (int k = 1; k <= nClk; k++) begin // Falls counted from trigger.
         convClk <= 1'b1;
         repeat (phase) @(posedge sys_clk); // Longer phase gives a slower rate.
         convClk <= 1'b0;
         repeat (phase) @(posedge sys_clk);
         capBit[k] = dataPin; // Taken as the clock rises again.
         capOe[k] = dataOe;
         // The next pass raises the clock in this same step; the last pass leaves it low.
         if (k == riseAt) sampleHoldTrigger <= 1'b1;
         if (k == fallAt) sampleHoldTrigger <= 1'b0;
      end
      @(posedge sys_clk);
   endtask

   // Raise the trigger to leave power-down.
   task automatic wake();
      @(posedge sys_clk);
      sampleHoldTrigger <= 1'b1;
   endtask
endmodule

`default_nettype wire

// ===== tb.sv
// Self-checking bench for the conversion control.
// Assumes the host model drives trigger and clock; the checker is bound.

`timescale 1ns/1ps
`default_nettype none

module tb;
   logic sys_clk;
   logic rst_b;
   logic compHigh;
   logic [11:0] ainCode;
   logic sampleHoldTrigger, convClk, serialData, serialDataOe, sampleMode, powerDown;
   logic resultValid, acquireShort, holdDroopLate, dataPin;
   logic [11:0] dacTrial, resultWord;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;

   sac_sample_hold_trigger_ctrl u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .sampleHoldTrigger(sampleHoldTrigger), .convClk(convClk), .compHigh(compHigh),
      .serialData(serialData), .serialDataOe(serialDataOe), .sampleMode(sampleMode),
      .powerDown(powerDown), .dacTrial(dacTrial), .resultWord(resultWord),
      .resultValid(resultValid), .acquireShort(acquireShort), .holdDroopLate(holdDroopLate));
   sac_host_model u_host (.sys_clk(sys_clk), .dataPin(dataPin), .dataOe(serialDataOe),
      .sampleHoldTrigger(sampleHoldTrigger), .convClk(convClk));

   // Pull-up on the data pin shows a released pin as high.
   assign dataPin = serialDataOe ? serialData : 1'b1;

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Comparator for an input half a step above ainCode.
   always @(posedge sys_clk) compHigh <= (dacTrial <= ainCode);

   // Watchdog against a hung run.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("[FAIL] %0t run too long", $time);
         close_out();
      end
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_msb(input logic [11:0] exp, input int last);
      for (int k = 2; k <= last; k++)
         chk({u_host.capOe[k], u_host.capBit[k]}, {1'b1, exp[13-k]}, "msb first bit");
   endtask

   task automatic wake_check(input string what);
      u_host.wake();
      repeat (8) @(posedge sys_clk);
      chk({powerDown, sampleMode, serialDataOe}, 3'b010, what);
   endtask

   // Trigger low all through: full result MSB first, then power-down.
   task automatic t_power_down(input logic [11:0] ain, input int phase);
      logic [11:0] exp;
      ainCode = ain;
      exp = ain ^ 12'h800;
      chk(serialDataOe, 0, "idle enable");
      u_host.frame(16, 0, 0, phase, 50, 10);
      chk({u_host.capOe[1], u_host.capBit[1]}, 2'b10, "start bit");
      chk_msb(exp, 13);
      chk(u_host.capOe[14], 0, "end release");
      chk(resultWord, exp, "result");
      chk({powerDown, sampleMode, acquireShort, holdDroopLate}, 4'h8, "asleep");
      wake_check("wake");
      $display("test power_down %h done", ain);
   endtask

   // Trigger raised before clock 13: no power-down, extra clocks ignored.
   task automatic t_normal();
      ainCode = 12'h3c1;
      u_host.frame(20, 12, 0, 6, 50, 10);
      chk_msb(12'hbc1, 12);
      for (int k = 13; k <= 20; k++) chk(u_host.capOe[k], 0, "released");
      chk({powerDown, sampleMode}, 2'b01, "back to sample");
      chk(resultWord, 12'hbc1, "result");
      $display("test normal done");
   endtask

   // Trigger up in clock 11, down in clock 13: resend LSB first.
   task automatic t_lsb_first();
      logic [11:0] exp;
      ainCode = 12'hc35;
      exp = 12'h435;
      u_host.frame(26, 11, 13, 6, 50, 10);
      chk_msb(exp, 11);
      chk(u_host.capOe[12], 0, "released on rise");
      for (int k = 14; k <= 24; k++)
         chk({u_host.capOe[k], u_host.capBit[k]}, {1'b1, exp[k-13]}, "lsb bit");
      chk(u_host.capOe[25], 0, "lsb end release");
      chk({powerDown, sampleMode}, 2'b10, "lsb asleep");
      wake_check("lsb wake");
      $display("test lsb_first done");
   endtask

   // Short acquisition and a late clock: both monitors flag, the result is still right.
   task automatic t_host_timing();
      ainCode = 12'h6d2;
      u_host.frame(16, 0, 0, 6, 20, 700);
      chk(resultWord, 12'hed2, "late clock result");
      chk({powerDown, acquireShort, holdDroopLate}, 3'b111, "timing flags");
      wake_check("timing wake");
      $display("test host_timing done");
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      ainCode = 12'h000;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_power_down(12'hfff, 6);
      t_power_down(12'h800, 6);
      t_power_down(12'h000, 6);
      t_power_down(12'h5a3, 20);
      t_normal();
      t_lsb_first();
      t_host_timing();
      t_power_down(12'h9e7, 6);
      close_out();
   end
endmodule

`default_nettype wire
